// ===== rtl/sak_ctrl.sv
`timescale 1ns/100ps
`include "sak_map.svh"

module sak_ctrl
  import sak_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // External control pins
  input wire logic sweep_direction_pin_i,
  input wire logic sweep_hold_pin_i,
  input wire logic amplitude_keying_pin_i,
  input wire logic [2:0] profile_sel_i,
  input wire logic io_update_i,
  // Synthesizer core parameters
  output logic [31:0] freq_word_o,
  output logic [15:0] phase_word_o,
  output logic [11:0] amplitude_scale_word_o
);

  // ==========================================================
  // Declarations
  logic [31:0] ctrl1_shadow_r;
  logic [31:0] ctrl2_shadow_r;
  logic [31:0] ctrl1_act_r;
  logic [31:0] ctrl2_act_r;
  logic [31:0] lower_r;
  logic [31:0] upper_r;
  logic [31:0] step_up_r;
  logic [31:0] step_dn_r;
  logic [31:0] rate_r;
  logic [31:0] prof_freq_r [0:7];
  logic [31:0] prof_pa_r [0:7];
  logic [7:0] aw_addr_r;
  logic aw_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_full_r;
  logic do_write;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [4:0] pdiv_r;
  logic tick_r;
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic upd_d_r;
  logic upd_pend_r;
  logic dir_p_r;
  logic hold_p_r;
  logic key_p_r;
  logic [2:0] prof_p_r;
  logic start_r;
  logic key_en;
  logic ext_key_en;
  logic sweep_en;
  sak_dest_t dest;
  logic [31:0] freq_nxt;
  logic [15:0] phase_nxt;
  logic [11:0] amp_nxt;
  logic [11:0] prof_amp;
  sak_sweep_if sw_if ();

  // Byte-lane merge for a write
  function automatic logic [31:0] sak_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = new_w[8*b +: 8];
    end
    return res;
  endfunction

  // ==========================================================
  // Write address and data capture, either order
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      s_axi_awready_o <= 1'b1;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_i;
      s_axi_awready_o <= 1'b0;
    end
    else if (do_write)
    begin
      aw_full_r <= 1'b0;
    end
    else if (!aw_full_r && !s_axi_bvalid_o)
      s_axi_awready_o <= 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_wready_o <= 1'b1;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata_i;
      w_strb_r <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end
    else if (do_write)
    begin
      w_full_r <= 1'b0;
    end
    else if (!w_full_r && !s_axi_bvalid_o)
      s_axi_wready_o <= 1'b1;
  end

  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid_o;

  // Writable address decode
  always_comb
  begin
    unique case (aw_addr_r[7:5])
      3'b000: wr_hit = (aw_addr_r[1:0] == 2'b00) && (aw_addr_r[4:2] <= 3'h6);
      3'b010: wr_hit = (aw_addr_r[1:0] == 2'b00);
      3'b011: wr_hit = (aw_addr_r[1:0] == 2'b00);
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `SAK_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_hit ? `SAK_RESP_OKAY : `SAK_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  // ==========================================================
  // Shadow control words and sweep settings
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctrl1_shadow_r <= `SAK_RST_WORD;
      ctrl2_shadow_r <= `SAK_RST_WORD;
      lower_r <= `SAK_RST_WORD;
      upper_r <= `SAK_RST_WORD;
      step_up_r <= `SAK_RST_WORD;
      step_dn_r <= `SAK_RST_WORD;
      rate_r <= `SAK_RST_WORD;
    end
    else if (do_write && wr_hit)
    begin
      unique case (aw_addr_r)
        `SAK_OFF_CTRL1: ctrl1_shadow_r <= sak_merge(ctrl1_shadow_r, w_data_r, w_strb_r);
        `SAK_OFF_CTRL2: ctrl2_shadow_r <= sak_merge(ctrl2_shadow_r, w_data_r, w_strb_r);
        `SAK_OFF_LOWER: lower_r <= sak_merge(lower_r, w_data_r, w_strb_r);
        `SAK_OFF_UPPER: upper_r <= sak_merge(upper_r, w_data_r, w_strb_r);
        `SAK_OFF_STEP_UP: step_up_r <= sak_merge(step_up_r, w_data_r, w_strb_r);
        `SAK_OFF_STEP_DN: step_dn_r <= sak_merge(step_dn_r, w_data_r, w_strb_r);
        `SAK_OFF_RATE: rate_r <= sak_merge(rate_r, w_data_r, w_strb_r);
        default: rate_r <= rate_r;
      endcase
    end
  end

  // Eight profile entries
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_prof
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          prof_freq_r[gi] <= `SAK_RST_WORD;
          prof_pa_r[gi] <= `SAK_RST_WORD;
        end
        else if (do_write && (aw_addr_r[4:2] == 3'(gi)) && (aw_addr_r[1:0] == 2'b00))
        begin
          if (aw_addr_r[7:5] == 3'b010)
            prof_freq_r[gi] <= sak_merge(prof_freq_r[gi], w_data_r, w_strb_r);
          else if (aw_addr_r[7:5] == 3'b011)
            prof_pa_r[gi] <= sak_merge(prof_pa_r[gi], w_data_r, w_strb_r);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read path
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = (s_axi_araddr_i[1:0] == 2'b00);
    unique case (s_axi_araddr_i[7:5])
      3'b000:
      begin
        unique case (s_axi_araddr_i[4:2])
          3'h0: rd_word = ctrl1_shadow_r;
          3'h1: rd_word = ctrl2_shadow_r;
          3'h2: rd_word = lower_r;
          3'h3: rd_word = upper_r;
          3'h4: rd_word = step_up_r;
          3'h5: rd_word = step_dn_r;
          3'h6: rd_word = rate_r;
          3'h7: rd_word = sw_if.sweep_out;
        endcase
      end
      3'b001:
      begin
        rd_hit = rd_hit && (s_axi_araddr_i[4:2] == 3'h0);
        rd_word = {24'h00_0000, upd_pend_r, prof_p_r, key_p_r, hold_p_r, dir_p_r, sweep_en};
      end
      3'b010: rd_word = prof_freq_r[s_axi_araddr_i[4:2]];
      3'b011: rd_word = prof_pa_r[s_axi_araddr_i[4:2]];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `SAK_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_hit ? rd_word : 32'h0000_0000;
      s_axi_rresp_o <= rd_hit ? `SAK_RESP_OKAY : `SAK_RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ==========================================================
  // Parameter clock tick, one in 24 system cycles
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      pdiv_r <= 5'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      pdiv_r <= (pdiv_r == `SAK_PDIV_LAST) ? 5'h00 : pdiv_r + 5'h01;
      tick_r <= (pdiv_r == `SAK_PDIV_LAST);
    end
  end

  // Two-stage synchronisers for all pins
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end
    else
    begin
      sync1_r <= {io_update_i, profile_sel_i, amplitude_keying_pin_i, sweep_hold_pin_i,
                  sweep_direction_pin_i};
      sync2_r <= sync1_r;
    end
  end

  // Pin levels taken on parameter ticks
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      dir_p_r <= 1'b0;
      hold_p_r <= 1'b0;
      key_p_r <= 1'b0;
      prof_p_r <= 3'h0;
    end
    else if (tick_r)
    begin
      dir_p_r <= sync2_r[0];
      hold_p_r <= sync2_r[1];
      key_p_r <= sync2_r[2];
      prof_p_r <= sync2_r[5:3];
    end
  end

  // ==========================================================
  // Update event: control words become active on the next tick
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      upd_d_r <= 1'b0;
      upd_pend_r <= 1'b0;
      ctrl1_act_r <= `SAK_RST_WORD;
      ctrl2_act_r <= `SAK_RST_WORD;
      start_r <= 1'b0;
    end
    else
    begin
      upd_d_r <= sync2_r[6];
      if (sync2_r[6] && !upd_d_r)
        upd_pend_r <= 1'b1; // New event wins over clear
      else if (tick_r)
        upd_pend_r <= 1'b0;
      if (tick_r)
        start_r <= 1'b0;
      if (tick_r && upd_pend_r)
      begin
        ctrl1_act_r <= ctrl1_shadow_r;
        ctrl2_act_r <= ctrl2_shadow_r;
        start_r <= ctrl2_shadow_r[`SAK_BIT_SWEEP_EN] && !ctrl2_act_r[`SAK_BIT_SWEEP_EN];
      end
    end
  end

  assign key_en = ctrl1_act_r[`SAK_BIT_KEY_EN];
  assign ext_key_en = ctrl1_act_r[`SAK_BIT_EXT_KEY_EN];
  assign sweep_en = ctrl2_act_r[`SAK_BIT_SWEEP_EN];
  assign dest = sak_dest_t'(ctrl2_act_r[`SAK_BIT_DEST_HI:`SAK_BIT_DEST_LO]);

  // ==========================================================
  // Sweep core hookup
  assign sw_if.tick = tick_r;
  assign sw_if.enable = sweep_en;
  assign sw_if.start = start_r;
  assign sw_if.dir = dir_p_r;
  assign sw_if.hold = hold_p_r;
  assign sw_if.lower = lower_r;
  assign sw_if.upper = upper_r;
  assign sw_if.step_up = step_up_r;
  assign sw_if.step_dn = step_dn_r;
  assign sw_if.rate_up = rate_r[`SAK_RATE_UP_LSB +: 16];
  assign sw_if.rate_dn = rate_r[`SAK_RATE_DN_LSB +: 16];

  sak_sweep u_sweep (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sw(sw_if.core)
  );

  // ==========================================================
  // Parameter selection with keying priority
  assign prof_amp = prof_pa_r[prof_p_r][`SAK_PA_AMP_LSB +: 12];

  always_comb
  begin
    freq_nxt = prof_freq_r[prof_p_r];
    phase_nxt = prof_pa_r[prof_p_r][15:0];
    amp_nxt = prof_amp;
    if (sweep_en)
    begin
      unique case (dest)
        SAK_DEST_FREQ: freq_nxt = sw_if.sweep_out;
        SAK_DEST_PHASE: phase_nxt = {sw_if.sweep_out[31:18], 2'b00};
        SAK_DEST_AMP, SAK_DEST_AMP_ALT: amp_nxt = sw_if.sweep_out[31:20];
      endcase
    end
    if (key_en)
    begin
      if (ext_key_en && !key_p_r)
        amp_nxt = 12'h000;
      else
        amp_nxt = prof_amp;
    end
  end

  // Registered parameter outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      freq_word_o <= 32'h0000_0000;
      phase_word_o <= 16'h0000;
      amplitude_scale_word_o <= 12'h000;
    end
    else
    begin
      freq_word_o <= freq_nxt;
      phase_word_o <= phase_nxt;
      amplitude_scale_word_o <= amp_nxt;
    end
  end

endmodule

// ===== rtl/sak_map.svh
`ifndef SAK_MAP_SVH
`define SAK_MAP_SVH

// ==========================================================
// Register byte offsets
`define SAK_OFF_CTRL1 8'h00
`define SAK_OFF_CTRL2 8'h04
`define SAK_OFF_LOWER 8'h08
`define SAK_OFF_UPPER 8'h0C
`define SAK_OFF_STEP_UP 8'h10
`define SAK_OFF_STEP_DN 8'h14
`define SAK_OFF_RATE 8'h18
`define SAK_OFF_SWEEP_OUT 8'h1C
`define SAK_OFF_PIN_STAT 8'h20
`define SAK_OFF_PROF_FREQ 8'h40
`define SAK_OFF_PROF_PA 8'h60

// ==========================================================
// Field positions
`define SAK_BIT_KEY_EN 8
`define SAK_BIT_EXT_KEY_EN 9
`define SAK_BIT_SWEEP_EN 19
`define SAK_BIT_DEST_LO 20
`define SAK_BIT_DEST_HI 21
`define SAK_RATE_UP_LSB 0
`define SAK_RATE_DN_LSB 16
`define SAK_PA_AMP_LSB 16

// ==========================================================
// Reset values and timing
`define SAK_RST_WORD 32'h0000_0000
`define SAK_PDIV_LAST 5'h17
`define SAK_RESP_OKAY 2'h0
`define SAK_RESP_SLVERR 2'h2

`endif

// ===== rtl/sak_pkg.sv
package sak_pkg;

  // Sweep destination codes
  typedef enum logic [1:0] {
    SAK_DEST_FREQ = 2'b00,
    SAK_DEST_PHASE = 2'b01,
    SAK_DEST_AMP = 2'b10,
    SAK_DEST_AMP_ALT = 2'b11
  } sak_dest_t;

  typedef logic [31:0] sak_word_t;
  typedef logic [15:0] sak_rate_t;

endpackage

// ===== rtl/sak_sweep_if.sv
`timescale 1ns/100ps

// Configuration and result of the sweep core
interface sak_sweep_if;
  logic tick;
  logic enable;
  logic start;
  logic dir;
  logic hold;
  logic [31:0] lower;
  logic [31:0] upper;
  logic [31:0] step_up;
  logic [31:0] step_dn;
  logic [15:0] rate_up;
  logic [15:0] rate_dn;
  logic [31:0] sweep_out;

  modport ctrl (
    output tick, enable, start, dir, hold, lower, upper,
    output step_up, step_dn, rate_up, rate_dn,
    input sweep_out
  );

  modport core (
    input tick, enable, start, dir, hold, lower, upper,
    input step_up, step_dn, rate_up, rate_dn,
    output sweep_out
  );
endinterface

// ===== rtl/sak_sweep.sv
`timescale 1ns/100ps

module sak_sweep
  import sak_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Sweep control
  sak_sweep_if.core sw
);

  logic [31:0] acc_r;
  logic [15:0] timer_r;
  logic dir_d_r;
  logic [32:0] sum_up;
  logic [32:0] diff_dn;
  logic [31:0] acc_step;
  logic [15:0] rate_sel;
  logic expire;

  // ==========================================================
  // Step arithmetic with limit clamping
  always_comb
  begin
    sum_up = {1'b0, acc_r} + {1'b0, sw.step_up};
    diff_dn = {1'b0, acc_r} - {1'b0, sw.step_dn};
    if (sw.dir)
    begin
      if (sum_up[32] || sum_up[31:0] > sw.upper)
        acc_step = sw.upper;
      else
        acc_step = sum_up[31:0];
    end
    else
    begin
      if (diff_dn[32] || diff_dn[31:0] < sw.lower)
        acc_step = sw.lower;
      else
        acc_step = diff_dn[31:0];
    end
  end

  // Interval select per slope, zero treated as one
  assign rate_sel = sw.dir ? sw.rate_up : sw.rate_dn;
  assign expire = (rate_sel == 16'h0000) || (timer_r >= rate_sel - 16'h0001);

  // ==========================================================
  // Accumulator and interval timer on parameter ticks
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      acc_r <= 32'h0000_0000;
      timer_r <= 16'h0000;
      dir_d_r <= 1'b0;
    end
    else if (sw.tick && sw.enable)
    begin
      dir_d_r <= sw.dir;
      if (sw.start)
      begin
        acc_r <= sw.lower;
        timer_r <= 16'h0000;
      end
      else if (sw.hold)
      begin
        // Frozen at last state
        acc_r <= acc_r;
      end
      else if (sw.dir != dir_d_r)
        timer_r <= 16'h0000; // Reload on direction change
      else if (expire)
      begin
        timer_r <= 16'h0000;
        acc_r <= acc_step;
      end
      else
        timer_r <= timer_r + 16'h0001;
    end
  end

  // ==========================================================
  // Output kept inside the limits
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      sw.sweep_out <= 32'h0000_0000;
    else if (acc_r > sw.upper) // Tracks frozen acc while disabled, old word shown at enable until start loads lower on a tick
      sw.sweep_out <= sw.upper;
    else if (acc_r < sw.lower)
      sw.sweep_out <= sw.lower;
    else
      sw.sweep_out <= acc_r;
  end

endmodule

// ===== tb/sak_pin_model.sv
`timescale 1ns/100ps

// ==========================================================
// External controller driving sweep, keying and profile pins
module sak_pin_model
(
  // Clock
  input wire logic clk_sys_i,
  // Pins toward the block
  output logic dir_o,
  output logic hold_o,
  output logic key_o,
  output logic [2:0] prof_o,
  output logic upd_o
);
  // Idle levels from time zero
  initial
  begin
    dir_o = 1'b0;
    hold_o = 1'b0;
    key_o = 1'b0;
    prof_o = 3'h0;
    upd_o = 1'b0;
  end

  // Level change just after an edge
  task automatic set_pins(input logic dir, input logic hold, input logic key, input logic [2:0] prof);
    dir_o <= dir;
    hold_o <= hold;
    key_o <= key;
    prof_o <= prof;
  endtask

  // Update event, each level held past the synchroniser
  task automatic pulse_update();
    upd_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    upd_o <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
endmodule

// ===== tb/sak_ctrl_props.sv
`timescale 1ns/100ps

// ==========================================================
// Port checker
module sak_ctrl_props
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins and parameters
  input wire logic amplitude_keying_pin_i,
  input wire logic [2:0] profile_sel_i,
  input wire logic [31:0] freq_word_o,
  input wire logic [15:0] phase_word_o,
  input wire logic [11:0] amplitude_scale_word_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  chk_b_after_wr:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write response missing");
  chk_b_holds:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  chk_wr_busy:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response open");
  chk_b_clears:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o ##1 s_axi_awready_o && s_axi_wready_o)
    else $error("write channel not freed");
  chk_r_after_ar:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read data missing");
  chk_r_holds:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  chk_reset_quiet:
    assert property ($fell(rst_i) |-> !s_axi_bvalid_o && !s_axi_rvalid_o && freq_word_o == 32'h0000_0000
      && phase_word_o == 16'h0000 && amplitude_scale_word_o == 12'h000)
    else $error("outputs not idle after reset");
  chk_pin_synced:
    assert property (($changed(amplitude_keying_pin_i) || $changed(profile_sel_i)) && s_axi_awready_o
      && !s_axi_awvalid_i |=> $stable(amplitude_scale_word_o) [*2])
    else $error("pin reached amplitude unsynchronised");
endmodule

bind sak_ctrl sak_ctrl_props i_props (.clk_sys_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .amplitude_keying_pin_i, .profile_sel_i, .freq_word_o,
  .phase_word_o, .amplitude_scale_word_o);

// ===== tb/sak_ctrl_tb.sv
`timescale 1ns/100ps
`include "sak_map.svh"

module sak_ctrl_tb
  import sak_pkg::*;
  ;
  // ==========================================================
  // Signals
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dir, hold, key, upd;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, freq;
  logic [15:0] phase;
  logic [11:0] amp;
  logic [2:0] prof;
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  sak_word_t v;
  localparam sak_word_t LIM_LO = 32'h2345_6789;
  localparam sak_word_t LIM_HI = 32'h2745_6789;
  localparam sak_word_t STEP_UP = 32'h0100_0000;
  localparam sak_word_t STEP_DN = 32'h0180_0000;

  // Clock
  always #2 clk_sys_i = ~clk_sys_i;

  sak_pin_model i_pins (.clk_sys_i(clk_sys_i), .dir_o(dir), .hold_o(hold), .key_o(key), .prof_o(prof),
    .upd_o(upd));

  sak_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sweep_direction_pin_i(dir),
    .sweep_hold_pin_i(hold), .amplitude_keying_pin_i(key), .profile_sel_i(prof), .io_update_i(upd),
    .freq_word_o(freq), .phase_word_o(phase), .amplitude_scale_word_o(amp));

  // ==========================================================
  // Profile contents
  function automatic sak_word_t pf(input int i);
    return 32'(32'h1111_1111 * (i + 1));
  endfunction
  function automatic logic [15:0] pph(input int i);
    return 16'(16'h1001 * (i + 1));
  endfunction
  function automatic logic [11:0] pam(input int i);
    return 12'(12'h101 * (i + 1));
  endfunction

  // ==========================================================
  // Report, compare and bus tasks
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_up();
    n_mismatch++;
    $display("ERROR wait limit expected answer seen none");
    close_out();
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (++k > 100)
        give_up();
    end while (awvalid || wvalid);
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (++k > 200)
        give_up();
    end while (!bvalid);
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(exp));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (++k > 100)
        give_up();
    end while (!arready);
    arvalid <= 1'b0;
    cyc(1);
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (++k > 200)
        give_up();
    end while (!rvalid);
    rready <= 1'b0;
    check("rdata", rdata, exp);
    check("rresp", 32'(rresp), 32'(exp_resp));
  endtask
  task automatic apply();
    i_pins.pulse_update();
    cyc(60);
  endtask
  task automatic wait_change(output int k);
    logic [31:0] prev;
    prev = freq;
    k = 0;
    do
    begin
      @(posedge clk_sys_i);
      k++;
    end while (freq === prev && k < 400);
    if (k >= 400)
      give_up();
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    cyc(6);
    rst_i <= 1'b0;
    cyc(1);
    axi_rd(`SAK_OFF_CTRL1, 32'h0, `SAK_RESP_OKAY);
    axi_rd(`SAK_OFF_CTRL2, 32'h0, `SAK_RESP_OKAY);
    axi_rd(8'h3C, 32'h0, `SAK_RESP_SLVERR);
    axi_wr(`SAK_OFF_SWEEP_OUT, 32'h1, `SAK_RESP_SLVERR);
    $display("Test reset and decode done");
    for (int i = 0; i < 8; i++)
    begin
      axi_wr(`SAK_OFF_PROF_FREQ + 8'(4 * i), pf(i), `SAK_RESP_OKAY);
      axi_wr(`SAK_OFF_PROF_PA + 8'(4 * i), {4'h0, pam(i), pph(i)}, `SAK_RESP_OKAY);
    end
    for (int i = 0; i < 8; i++)
    begin
      i_pins.set_pins(1'b0, 1'b0, 1'b0, 3'(i));
      cyc(60);
      check("profile freq", freq, pf(i));
      check("profile phase", 32'(phase), 32'(pph(i)));
      check("profile amp", 32'(amp), 32'(pam(i)));
    end
    i_pins.set_pins(1'b0, 1'b0, 1'b0, 3'h0);
    $display("Test profiles done");
    axi_wr(`SAK_OFF_CTRL1, 32'h0000_0300, `SAK_RESP_OKAY);
    cyc(60);
    check("keying before update", 32'(amp), 32'(pam(0)));
    apply();
    check("keying pin low", 32'(amp), 32'h0);
    i_pins.set_pins(1'b0, 1'b0, 1'b1, 3'h2);
    cyc(60);
    check("keying pin high", 32'(amp), 32'(pam(2)));
    i_pins.set_pins(1'b0, 1'b0, 1'b0, 3'h0);
    axi_wr(`SAK_OFF_CTRL1, 32'h0000_0200, `SAK_RESP_OKAY);
    apply();
    check("keying disabled", 32'(amp), 32'(pam(0)));
    $display("Test keying done");
    axi_wr(`SAK_OFF_LOWER, LIM_LO, `SAK_RESP_OKAY);
    axi_wr(`SAK_OFF_UPPER, LIM_HI, `SAK_RESP_OKAY);
    axi_wr(`SAK_OFF_STEP_UP, STEP_UP, `SAK_RESP_OKAY);
    axi_wr(`SAK_OFF_STEP_DN, STEP_DN, `SAK_RESP_OKAY);
    axi_wr(`SAK_OFF_RATE, {16'd3, 16'd2}, `SAK_RESP_OKAY);
    i_pins.set_pins(1'b1, 1'b0, 1'b0, 3'h0);
    axi_wr(`SAK_OFF_CTRL2, 32'h0008_0000, `SAK_RESP_OKAY);
    apply();
    check("sweep start", freq, LIM_LO);
    wait_change(n);
    check("rising step", freq, LIM_LO + STEP_UP);
    wait_change(n);
    check("rising interval", 32'(n), 32'd48);
    cyc(300);
    check("upper clamp", freq, LIM_HI);
    axi_rd(`SAK_OFF_SWEEP_OUT, LIM_HI, `SAK_RESP_OKAY);
    i_pins.set_pins(1'b0, 1'b0, 1'b0, 3'h0);
    wait_change(n);
    check("falling step", freq, LIM_HI - STEP_DN);
    wait_change(n);
    check("falling interval", 32'(n), 32'd72);
    i_pins.set_pins(1'b0, 1'b1, 1'b0, 3'h0);
    cyc(60);
    v = freq;
    cyc(150);
    check("hold", freq, v);
    i_pins.set_pins(1'b0, 1'b0, 1'b0, 3'h0);
    cyc(250);
    check("lower clamp", freq, LIM_LO);
    $display("Test sweep done");
    axi_wr(`SAK_OFF_CTRL2, 32'h0018_0000, `SAK_RESP_OKAY);
    apply();
    check("phase dest", 32'(phase), 32'({LIM_LO[31:18], 2'b00}));
    check("freq from profile", freq, pf(0));
    for (int c = 2; c < 4; c++)
    begin
      axi_wr(`SAK_OFF_CTRL2, {10'h0, 2'(c), 20'h8_0000}, `SAK_RESP_OKAY);
      apply();
      check("amp dest", 32'(amp), 32'(LIM_LO[31:20]));
      check("phase from profile", 32'(phase), 32'(pph(0)));
    end
    axi_wr(`SAK_OFF_CTRL1, 32'h0000_0100, `SAK_RESP_OKAY);
    apply();
    check("keying over sweep", 32'(amp), 32'(pam(0)));
    axi_wr(`SAK_OFF_CTRL2, 32'h0010_0000, `SAK_RESP_OKAY);
    apply();
    i_pins.set_pins(1'b1, 1'b0, 1'b0, 3'h0);
    cyc(200);
    axi_rd(`SAK_OFF_SWEEP_OUT, LIM_LO, `SAK_RESP_OKAY);
    axi_rd(`SAK_OFF_PIN_STAT, 32'h0000_0002, `SAK_RESP_OKAY);
    check("phase sweep off", 32'(phase), 32'(pph(0)));
    $display("Test routing done");
    close_out();
  end
endmodule
